/* File: rtl/ffs_pkg.sv */
// package for the fault flag and first fault id status block
// holds register indices, bit positions, reset values and the input bundle
package ffs_pkg;

   // ==========================================================
   // register indices, byte address is four times the index
   localparam logic [15:0] IDX_GRP4_LIVE    = 16'hFEC3;
   localparam logic [15:0] IDX_GRP4_LATCHED = 16'hFEC8;
   localparam logic [15:0] IDX_GRP5_LIVE    = 16'hFEC4;
   localparam logic [15:0] IDX_GRP5_LATCHED = 16'hFEC9;
   localparam logic [15:0] IDX_FIRST_ID_A   = 16'hFECA;
   localparam logic [15:0] IDX_FIRST_ID_B   = 16'hFECB;
   localparam logic [15:0] IDX_IRQ_STATUS   = 16'hFEE0;
   localparam logic [15:0] IDX_IRQ_CLEAR    = 16'hFEE1;
   localparam logic [15:0] IDX_IRQ_ENABLE   = 16'hFEE2;

   // ==========================================================
   // address split and bus codes
   localparam int          IDX_LSB      = 2;
   localparam int          IDX_MSB      = 17;
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic        HRESP_OKAY   = 1'h0;

   // ==========================================================
   // group four bit positions
   localparam int B4_CHAN_C_OFF   = 6;
   localparam int B4_FLAG_PIN     = 5;
   localparam int B4_NVM_UNLOCKED = 4;
   localparam int B4_RAMP_B       = 3;
   localparam int B4_RAMP_A       = 2;
   localparam int B4_CLAMP_B      = 1;
   localparam int B4_CLAMP_A      = 0;

   // group five bit positions
   localparam int B5_ZONE2_WARN = 3;
   localparam int B5_ZONE1_WARN = 2;
   localparam int B5_REVERSE_B  = 1;
   localparam int B5_REVERSE_A  = 0;

   // ==========================================================
   // valid bit masks and reset values
   localparam logic [7:0] GRP4_MASK     = 8'h7F;
   localparam logic [7:0] GRP5_MASK     = 8'h0F;
   localparam logic [7:0] FLAGS_RESET   = 8'h00;
   localparam logic [7:0] ID_RESET      = 8'h00;
   localparam logic       CHAN_C_OFF_RST = 1'h1;

   // ==========================================================
   // first fault codes: flag vector bit n carries code n+1
   localparam int         FAULT_FLAGS = 15;
   localparam int         CODE_W      = 4;
   localparam logic [3:0] CODE_NONE   = 4'h0;

   // interrupt event bits
   localparam int IRQ_W        = 4;
   localparam int EV_GRP4      = 0;
   localparam int EV_GRP5      = 1;
   localparam int EV_ID_A      = 2;
   localparam int EV_ID_B      = 3;
   localparam logic [3:0] IRQ_RESET = 4'h0;

   localparam int SYNC_STAGES = 3;

   // live conditions from the regulator logic, same clock
   typedef struct packed {
      logic       chan_c_shutdown;      // pulse: channel c turned off
      logic       light_load_flag_a;
      logic       light_load_flag_b;
      logic       nvm_unlocked;
      logic       ramp_filter_active_a;
      logic       ramp_filter_active_b;
      logic       loop_filter_clamped_a;
      logic       loop_filter_clamped_b;
      logic       zone1_temp_warning;
      logic       zone2_temp_warning;
      logic       reverse_current_a;    // secondary_sense_a below threshold
      logic       reverse_current_b;    // secondary_sense_b below threshold
      logic       chan_a_shutdown;      // level: channel a held off by a fault
      logic       chan_b_shutdown;      // level: channel b held off by a fault
      logic [14:0] fault_flags;         // flags that trigger a soft start response
   } ffs_status_in_t;

endpackage : ffs_pkg

/* File: rtl/ffs_status.sv */
// fault flag groups four and five, live and latched, plus first fault ids
// assumes one clock domain, an ahb-lite master and flag sources on i_clk
//
// Summary of operation
// [R1] group four live and latched copies
// [R2] channel c off until power-on input
// [R3] flag pin active from light load flags
// [R4] nonvolatile storage unlocked flag
// [R5] ramp filter in use, b and a
// [R6] loop filter clamped, b and a
// [R7] group five live, latched, upper nibble reserved
// [R8] zone temperature warnings two and one
// [R9] reverse current b and a
// [R10] one first fault id per channel
// [R11] id records only own channel shutdowns
// [R12] low nibble holds present shutdown code
// [R13] high nibble previous code, fixed code table
// [R14] new record shifts low nibble up
// [R15] latched bits stick until read
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module ffs_status (
   input  wire logic                  i_clk,
   input  wire logic                  i_sys_rst,
   input  wire logic                  i_hsel,
   input  wire logic [31:0]           i_haddr,
   input  wire logic [1:0]            i_htrans,
   input  wire logic                  i_hwrite,
   input  wire logic [2:0]            i_hsize,
   input  wire logic [31:0]           i_hwdata,
   input  wire logic                  i_hready,
   output logic      [31:0]           o_hrdata,
   output logic                       o_hreadyout,
   output logic                       o_hresp,
   input  wire ffs_pkg::ffs_status_in_t i_status,
   input  wire logic                  i_chan_c_power_on_input,
   output logic                       o_flag_output_pin,
   output logic                       o_irq
);

   // ==========================================================
   // helpers
   // lowest flag wins when several trip in the same cycle
   function automatic logic [3:0] first_code(input logic [14:0] flags);
      logic [3:0] code;
      code = ffs_pkg::CODE_NONE;
      for (int n = ffs_pkg::FAULT_FLAGS - 1; n >= 0; n--) begin
         if (flags[n]) begin
            code = 4'(n + 1);  // [R13]
         end
      end
      return code;
   endfunction : first_code

   function automatic logic hit(input logic [31:0] a, input logic [15:0] idx);
      return (a[ffs_pkg::IDX_MSB:ffs_pkg::IDX_LSB] == idx) && (a[31:18] == 14'h0)
             && (a[1:0] == 2'h0);
   endfunction : hit

   // ==========================================================
   // power-on input synchroniser
   logic [ffs_pkg::SYNC_STAGES-1:0] pon_sync_q;
   logic                            pon_stable_q;
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         pon_sync_q <= '0;
      end else begin
         pon_sync_q <= {pon_sync_q[ffs_pkg::SYNC_STAGES-2:0], i_chan_c_power_on_input};
      end
   end
   wire pon_agree = (pon_sync_q[1] == pon_sync_q[2]);
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         pon_stable_q <= 1'b0;
      end else if (pon_agree) begin
         pon_stable_q <= pon_sync_q[2];
      end
   end

   // ==========================================================
   // bus address phase
   wire        take      = i_hsel && i_hready && (i_htrans == ffs_pkg::HTRANS_NONSEQ);
   wire        take_rd   = take && !i_hwrite;
   wire        take_wr   = take && i_hwrite;
   logic       wr_pend_q;
   logic [31:0] wr_addr_q;
   wire        wr_clear  = wr_pend_q && hit(wr_addr_q, ffs_pkg::IDX_IRQ_CLEAR);
   wire        wr_enable = wr_pend_q && hit(wr_addr_q, ffs_pkg::IDX_IRQ_ENABLE);
   wire        rd_lat4   = take_rd && hit(i_haddr, ffs_pkg::IDX_GRP4_LATCHED);
   wire        rd_lat5   = take_rd && hit(i_haddr, ffs_pkg::IDX_GRP5_LATCHED);

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 32'h0;
      end else begin
         wr_pend_q <= take_wr;
         wr_addr_q <= take_wr ? i_haddr : wr_addr_q;
      end
   end

   // ==========================================================
   // channel c off flag
   logic chan_c_off_q;
   wire  chan_c_off_d = i_status.chan_c_shutdown ? 1'b1 :
                        (pon_stable_q ? 1'b0 : chan_c_off_q);  // [R2]
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         chan_c_off_q <= ffs_pkg::CHAN_C_OFF_RST;
      end else begin
         chan_c_off_q <= chan_c_off_d;
      end
   end

   // ==========================================================
   // live flag groups
   // chan c starts off, so both copies of group four leave reset with it set
   localparam logic [7:0] GRP4_RST =
      ffs_pkg::FLAGS_RESET | (8'(ffs_pkg::CHAN_C_OFF_RST) << ffs_pkg::B4_CHAN_C_OFF);
   logic [7:0] grp4_live_q;
   logic [7:0] grp5_live_q;
   logic       flag_pin_q;
   wire        flag_pin_active_flag = i_status.light_load_flag_a | i_status.light_load_flag_b;
   logic [7:0] grp4_live_d;
   logic [7:0] grp5_live_d;
   always_comb begin
      grp4_live_d = ffs_pkg::FLAGS_RESET;
      grp4_live_d[ffs_pkg::B4_CHAN_C_OFF]   = chan_c_off_d;                   // [R2]
      grp4_live_d[ffs_pkg::B4_FLAG_PIN]     = flag_pin_active_flag;           // [R3]
      grp4_live_d[ffs_pkg::B4_NVM_UNLOCKED] = i_status.nvm_unlocked;          // [R4]
      grp4_live_d[ffs_pkg::B4_RAMP_B]       = i_status.ramp_filter_active_b;  // [R5]
      grp4_live_d[ffs_pkg::B4_RAMP_A]       = i_status.ramp_filter_active_a;  // [R5]
      grp4_live_d[ffs_pkg::B4_CLAMP_B]      = i_status.loop_filter_clamped_b; // [R6]
      grp4_live_d[ffs_pkg::B4_CLAMP_A]      = i_status.loop_filter_clamped_a; // [R6]
      grp5_live_d = ffs_pkg::FLAGS_RESET;                                     // [R7]
      grp5_live_d[ffs_pkg::B5_ZONE2_WARN]   = i_status.zone2_temp_warning;    // [R8]
      grp5_live_d[ffs_pkg::B5_ZONE1_WARN]   = i_status.zone1_temp_warning;    // [R8]
      grp5_live_d[ffs_pkg::B5_REVERSE_B]    = i_status.reverse_current_b;     // [R9]
      grp5_live_d[ffs_pkg::B5_REVERSE_A]    = i_status.reverse_current_a;     // [R9]
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         grp4_live_q <= GRP4_RST;
         grp5_live_q <= ffs_pkg::FLAGS_RESET;
         flag_pin_q  <= 1'b0;
      end else begin
         grp4_live_q <= grp4_live_d & ffs_pkg::GRP4_MASK;  // [R1]
         grp5_live_q <= grp5_live_d & ffs_pkg::GRP5_MASK;  // [R7]
         flag_pin_q  <= flag_pin_active_flag;              // [R3]
      end
   end

   // ==========================================================
   // latched copies: a set arriving with the read-clear is kept
   logic [7:0] grp4_lat_q;
   logic [7:0] grp5_lat_q;
   wire  [7:0] grp4_lat_d = grp4_live_q | (grp4_lat_q & ~{8{rd_lat4}});  // [R15]
   wire  [7:0] grp5_lat_d = grp5_live_q | (grp5_lat_q & ~{8{rd_lat5}});  // [R15]
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         grp4_lat_q <= GRP4_RST;
         grp5_lat_q <= ffs_pkg::FLAGS_RESET;
      end else begin
         grp4_lat_q <= grp4_lat_d;  // [R1]
         grp5_lat_q <= grp5_lat_d;  // [R7]
      end
   end

   // ==========================================================
   // first fault ids, recorded on the rising edge of each shutdown
   logic       shut_a_q;
   logic       shut_b_q;
   logic [7:0] id_a_q;
   logic [7:0] id_b_q;
   wire        rec_a  = i_status.chan_a_shutdown && !shut_a_q;  // [R10]
   wire        rec_b  = i_status.chan_b_shutdown && !shut_b_q;  // [R10]
   wire  [3:0] code_now = first_code(i_status.fault_flags);
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         shut_a_q <= 1'b0;
         shut_b_q <= 1'b0;
         id_a_q   <= ffs_pkg::ID_RESET;
         id_b_q   <= ffs_pkg::ID_RESET;
      end else begin
         shut_a_q <= i_status.chan_a_shutdown;
         shut_b_q <= i_status.chan_b_shutdown;
         id_a_q   <= rec_a ? {id_a_q[3:0], code_now} : id_a_q;  // [R11] [R12] [R14]
         id_b_q   <= rec_b ? {id_b_q[3:0], code_now} : id_b_q;  // [R11] [R12] [R14]
      end
   end

   // ==========================================================
   // interrupt status, clear and enable
   logic [3:0] irq_stat_q;
   logic [3:0] irq_en_q;
   logic       irq_q;
   wire  [3:0] irq_ev = {rec_b, rec_a, |(grp5_live_q & ~grp5_lat_q),
                         |(grp4_live_q & ~grp4_lat_q)};
   wire  [3:0] irq_clr = wr_clear ? i_hwdata[3:0] : ffs_pkg::IRQ_RESET;
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         irq_stat_q <= ffs_pkg::IRQ_RESET;
         irq_en_q   <= ffs_pkg::IRQ_RESET;
         irq_q      <= 1'b0;
      end else begin
         irq_stat_q <= irq_ev | (irq_stat_q & ~irq_clr);
         irq_en_q   <= wr_enable ? i_hwdata[3:0] : irq_en_q;
         irq_q      <= |(irq_stat_q & irq_en_q);
      end
   end

   // ==========================================================
   // read data, registered in the address phase; enable is forwarded
   // so a read right behind its write sees the new value
   wire  [3:0] en_view = wr_enable ? i_hwdata[3:0] : irq_en_q;
   wire  [7:0] rd_byte =
      hit(i_haddr, ffs_pkg::IDX_GRP4_LIVE)    ? grp4_live_q :
      hit(i_haddr, ffs_pkg::IDX_GRP4_LATCHED) ? grp4_lat_q  :
      hit(i_haddr, ffs_pkg::IDX_GRP5_LIVE)    ? grp5_live_q :
      hit(i_haddr, ffs_pkg::IDX_GRP5_LATCHED) ? grp5_lat_q  :
      hit(i_haddr, ffs_pkg::IDX_FIRST_ID_A)   ? id_a_q      :
      hit(i_haddr, ffs_pkg::IDX_FIRST_ID_B)   ? id_b_q      :
      hit(i_haddr, ffs_pkg::IDX_IRQ_STATUS)   ? {4'h0, irq_stat_q} :
      hit(i_haddr, ffs_pkg::IDX_IRQ_ENABLE)   ? {4'h0, en_view}    : 8'h00;
   logic [31:0] hrdata_q;
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         hrdata_q <= 32'h0;
      end else if (take_rd) begin
         hrdata_q <= {24'h0, rd_byte};
      end
   end

   // zero wait states: every transfer completes in its first data cycle
   logic hready_q;
   logic hresp_q;
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         hready_q <= 1'b1;
         hresp_q  <= ffs_pkg::HRESP_OKAY;
      end else begin
         hready_q <= 1'b1;
         hresp_q  <= ffs_pkg::HRESP_OKAY;
      end
   end

   assign o_hrdata          = hrdata_q;
   assign o_hreadyout       = hready_q;
   assign o_hresp           = hresp_q;
   assign o_flag_output_pin = flag_pin_q;
   assign o_irq             = irq_q;

   // ==========================================================
   // assertions
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   property p_grp4_set;
      1 |=> ((grp4_lat_q & $past(grp4_live_q)) == $past(grp4_live_q));
   endproperty
   a_grp4_set: assert property (p_grp4_set) else $error("group4 live not latched"); // [R1]

   property p_lat_hold;
      !rd_lat4 |=> ((grp4_lat_q & $past(grp4_lat_q)) == $past(grp4_lat_q));
   endproperty
   a_lat_hold: assert property (p_lat_hold) else $error("latched bit lost"); // [R15]

   property p_grp5_rsvd;
      (grp5_live_q[7:4] == 4'h0) && (grp5_lat_q[7:4] == 4'h0);
   endproperty
   a_grp5_rsvd: assert property (p_grp5_rsvd) else $error("reserved bits set"); // [R7]

   property p_chan_c_hold;
      chan_c_off_q && !i_status.chan_c_shutdown && !pon_stable_q |=> chan_c_off_q;
   endproperty
   a_chan_c_hold: assert property (p_chan_c_hold) else $error("chan c off dropped"); // [R2]

   property p_flag_pin;
      1 |=> (grp4_live_q[ffs_pkg::B4_FLAG_PIN] ==
             ($past(i_status.light_load_flag_a) | $past(i_status.light_load_flag_b)))
            && (o_flag_output_pin == grp4_live_q[ffs_pkg::B4_FLAG_PIN]);
   endproperty
   a_flag_pin: assert property (p_flag_pin) else $error("flag pin mismatch"); // [R3]

   property p_nvm;
      1 |=> grp4_live_q[ffs_pkg::B4_NVM_UNLOCKED] == $past(i_status.nvm_unlocked);
   endproperty
   a_nvm: assert property (p_nvm) else $error("unlock flag wrong"); // [R4]

   property p_id_shift;
      rec_a |=> (id_a_q[7:4] == $past(id_a_q[3:0])) && (id_a_q[3:0] == $past(code_now));
   endproperty
   a_id_shift: assert property (p_id_shift) else $error("id a record wrong"); // [R14]

   property p_id_own;
      rec_a && !rec_b |=> $stable(id_b_q);
   endproperty
   a_id_own: assert property (p_id_own) else $error("id b touched by a"); // [R11]

   property p_code;
      (i_status.fault_flags != 15'h0) |-> (code_now != ffs_pkg::CODE_NONE);
   endproperty
   a_code: assert property (p_code) else $error("code lost"); // [R12]

   property p_irq;
      1 |=> o_irq == $past(|(irq_stat_q & irq_en_q));
   endproperty
   a_irq: assert property (p_irq) else $error("irq wrong");

   property p_grp5_set;
      1 |=> ((grp5_lat_q & $past(grp5_live_q)) == $past(grp5_live_q));
   endproperty
   a_grp5_set: assert property (p_grp5_set) else $error("group5 live not latched"); // [R7]

   property p_lat_hold5;
      !rd_lat5 |=> ((grp5_lat_q & $past(grp5_lat_q)) == $past(grp5_lat_q));
   endproperty
   a_lat_hold5: assert property (p_lat_hold5) else $error("group5 bit lost"); // [R15]

   // a read of the latched copy leaves only what is still live
   property p_lat_clear;
      rd_lat4 |=> (grp4_lat_q == $past(grp4_live_q));
   endproperty
   a_lat_clear: assert property (p_lat_clear) else $error("read clear failed"); // [R15]

   property p_chan_c_set;
      i_status.chan_c_shutdown |=> chan_c_off_q && grp4_live_q[ffs_pkg::B4_CHAN_C_OFF];
   endproperty
   a_chan_c_set: assert property (p_chan_c_set) else $error("chan c off not set"); // [R2]

   property p_id_shift_b;
      rec_b |=> (id_b_q[7:4] == $past(id_b_q[3:0])) && (id_b_q[3:0] == $past(code_now));
   endproperty
   a_id_shift_b: assert property (p_id_shift_b) else $error("id b record wrong"); // [R14]

   property p_id_own_b;
      rec_b && !rec_a |=> $stable(id_a_q);
   endproperty
   a_id_own_b: assert property (p_id_own_b) else $error("id a touched by b"); // [R11]

   // set wins over a clear in the same cycle
   property p_irq_set;
      1 |=> ((irq_stat_q & $past(irq_ev)) == $past(irq_ev));
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("irq event lost");

   c_lat_clear: cover property (rd_lat4 ##1 grp4_lat_q == 8'h00);
   c_rec_twice: cover property (rec_a ##[1:20] rec_a);
   c_pon: cover property (chan_c_off_q ##1 !chan_c_off_q);
   c_irq: cover property (!o_irq ##1 o_irq);
   c_rec_b: cover property (rec_b ##1 id_b_q != ffs_pkg::ID_RESET);

endmodule : ffs_status

/* File: tb/ffs_status_bench.sv */
// self-checking bench for the fault flag and first fault id status block
// waits on ready in both phases of every ahb-lite transfer, so no fixed wait count is assumed
`timescale 1ns/1ps
module ffs_status_bench;

   // ==========================================================
   // clock, reset and ports
   logic                   clk;
   logic                   rst;
   logic                   hsel;
   logic [31:0]            haddr;
   logic [1:0]             htrans;
   logic                   hwrite;
   logic [2:0]             hsize;
   logic [31:0]            hwdata;
   wire  logic             hready;
   logic [31:0]            hrdata;
   logic                   hreadyout;
   logic                   hresp;
   ffs_pkg::ffs_status_in_t st;
   logic                   pon;
   logic                   flag_pin;
   logic                   irq;
   int                     miscompares = 0;
   int                     checked = 0;

   // the single slave drives the bus ready
   assign hready = hreadyout;

   ffs_status dut (
      .i_clk                   (clk),
      .i_sys_rst               (rst),
      .i_hsel                  (hsel),
      .i_haddr                 (haddr),
      .i_htrans                (htrans),
      .i_hwrite                (hwrite),
      .i_hsize                 (hsize),
      .i_hwdata                (hwdata),
      .i_hready                (hready),
      .o_hrdata                (hrdata),
      .o_hreadyout             (hreadyout),
      .o_hresp                 (hresp),
      .i_status                (st),
      .i_chan_c_power_on_input (pon),
      .o_flag_output_pin       (flag_pin),
      .o_irq                   (irq)
   );

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ==========================================================
   // reporting and bus tasks
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   function automatic logic [31:0] ba(input logic [15:0] idx);
      ba = {14'h0000, idx, 2'h0};
   endfunction : ba

   // no wait count is assumed, only a bound against a hang
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 100);
      if (hready !== 1'b1) begin
         miscompares++;
         complete_run();
      end
   endtask : wait_rdy

   task automatic xfer(input logic [15:0] idx, input logic wr, input logic [31:0] wd,
                       output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= ba(idx);
      htrans <= ffs_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
      check("hresp", {31'h0, hresp}, {31'h0, ffs_pkg::HRESP_OKAY});
   endtask : xfer

   task automatic rdchk(input string name, input logic [15:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      xfer(idx, 1'b0, 32'h0, d);
      check(name, d, exp);
   endtask : rdchk

   task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
      logic [31:0] d;
      xfer(idx, 1'b1, wd, d);
   endtask : wr

   // one status input per flag: k below 8 is group four, 8 and up group five
   task automatic drv(input int k, input logic v);
      case (k)
         0:  st.loop_filter_clamped_a <= v;
         1:  st.loop_filter_clamped_b <= v;
         2:  st.ramp_filter_active_a <= v;
         3:  st.ramp_filter_active_b <= v;
         4:  st.nvm_unlocked <= v;
         5:  st.light_load_flag_a <= v;
         6:  st.light_load_flag_b <= v;
         8:  st.reverse_current_a <= v;
         9:  st.reverse_current_b <= v;
         10: st.zone1_temp_warning <= v;
         11: st.zone2_temp_warning <= v;
         default: ;
      endcase
   endtask : drv

   // ==========================================================
   // scenarios
   task automatic reset_test;
      rdchk("grp4_live", ffs_pkg::IDX_GRP4_LIVE, 32'h40);
      rdchk("grp5_live", ffs_pkg::IDX_GRP5_LIVE, 32'h00);
      rdchk("id_a", ffs_pkg::IDX_FIRST_ID_A, 32'h00);
      rdchk("id_b", ffs_pkg::IDX_FIRST_ID_B, 32'h00);
      rdchk("irq_en", ffs_pkg::IDX_IRQ_ENABLE, 32'h00);
      check("flag_pin", {31'h0, flag_pin}, 32'h0);
   endtask : reset_test

   task automatic chan_c_test;
      pon <= 1'b1;
      repeat (8) @(posedge clk);
      rdchk("chan_c_on", ffs_pkg::IDX_GRP4_LIVE, 32'h00);
      pon <= 1'b0;
      repeat (6) @(posedge clk);
      st.chan_c_shutdown <= 1'b1;
      @(posedge clk);
      st.chan_c_shutdown <= 1'b0;
      repeat (12) @(posedge clk);
      rdchk("chan_c_off", ffs_pkg::IDX_GRP4_LIVE, 32'h40);
      pon <= 1'b1;
      repeat (8) @(posedge clk);
      rdchk("chan_c_back", ffs_pkg::IDX_GRP4_LIVE, 32'h00);
   endtask : chan_c_test

   task automatic flags_test;
      logic [15:0] lv;
      logic [15:0] lt;
      logic [31:0] exp;
      rdchk("grp4_lat_drain", ffs_pkg::IDX_GRP4_LATCHED, 32'h40);
      for (int k = 0; k < 12; k++) begin
         if (k == 7) continue;
         lv = (k < 8) ? ffs_pkg::IDX_GRP4_LIVE : ffs_pkg::IDX_GRP5_LIVE;
         lt = (k < 8) ? ffs_pkg::IDX_GRP4_LATCHED : ffs_pkg::IDX_GRP5_LATCHED;
         // both light load flags drive bit five
         exp = (k == 6) ? 32'h20 : (32'h1 << (k % 8));
         drv(k, 1'b1);
         repeat (3) @(posedge clk);
         rdchk("live_set", lv, exp);
         if (k == 5 || k == 6) check("flag_pin", {31'h0, flag_pin}, 32'h1);
         drv(k, 1'b0);
         repeat (3) @(posedge clk);
         rdchk("live_clr", lv, 32'h0);
         rdchk("latched", lt, exp);
         rdchk("latched_read_clr", lt, 32'h0);
      end
      check("flag_pin", {31'h0, flag_pin}, 32'h0);
   endtask : flags_test

   task automatic rec(input logic chan_b, input logic [14:0] flags);
      st.fault_flags <= flags;
      @(posedge clk);
      if (chan_b) st.chan_b_shutdown <= 1'b1;
      else st.chan_a_shutdown <= 1'b1;
      repeat (2) @(posedge clk);
      st.chan_a_shutdown <= 1'b0;
      st.chan_b_shutdown <= 1'b0;
      st.fault_flags <= 15'h0000;
      repeat (2) @(posedge clk);
   endtask : rec

   task automatic id_test;
      logic [3:0] prev;
      rec(1'b0, 15'h0410);
      rdchk("id_a", ffs_pkg::IDX_FIRST_ID_A, 32'h05);
      rdchk("id_b_untouched", ffs_pkg::IDX_FIRST_ID_B, 32'h00);
      rec(1'b0, 15'h2000);
      rdchk("id_a_shift", ffs_pkg::IDX_FIRST_ID_A, 32'h5E);
      prev = 4'h0;
      for (int n = 0; n < 15; n++) begin
         rec(1'b1, 15'h0001 << n);
         rdchk("id_b", ffs_pkg::IDX_FIRST_ID_B, {24'h0, prev, 4'(n + 1)});
         prev = 4'(n + 1);
      end
      rdchk("id_a_kept", ffs_pkg::IDX_FIRST_ID_A, 32'h5E);
   endtask : id_test

   task automatic irq_test;
      wr(ffs_pkg::IDX_IRQ_ENABLE, 32'h0);
      wr(ffs_pkg::IDX_IRQ_CLEAR, 32'hF);
      rdchk("irq_status_clr", ffs_pkg::IDX_IRQ_STATUS, 32'h0);
      drv(10, 1'b1);
      repeat (3) @(posedge clk);
      drv(10, 1'b0);
      repeat (3) @(posedge clk);
      rdchk("irq_status_ev", ffs_pkg::IDX_IRQ_STATUS, 32'h2);
      check("irq_masked", {31'h0, irq}, 32'h0);
      wr(ffs_pkg::IDX_IRQ_ENABLE, 32'h2);
      rdchk("irq_en", ffs_pkg::IDX_IRQ_ENABLE, 32'h2);
      check("irq_on", {31'h0, irq}, 32'h1);
      wr(ffs_pkg::IDX_IRQ_CLEAR, 32'h2);
      repeat (2) @(posedge clk);
      check("irq_off", {31'h0, irq}, 32'h0);
      rdchk("irq_status_done", ffs_pkg::IDX_IRQ_STATUS, 32'h0);
      rec(1'b0, 15'h0001);
      rec(1'b1, 15'h0002);
      drv(0, 1'b1);
      repeat (3) @(posedge clk);
      drv(0, 1'b0);
      repeat (3) @(posedge clk);
      rdchk("irq_status_all", ffs_pkg::IDX_IRQ_STATUS, 32'hD);
      check("irq_masked_all", {31'h0, irq}, 32'h0);
      wr(ffs_pkg::IDX_IRQ_CLEAR, 32'hF);
      rdchk("irq_status_empty", ffs_pkg::IDX_IRQ_STATUS, 32'h0);
      rdchk("irq_clear_reads0", ffs_pkg::IDX_IRQ_CLEAR, 32'h0);
      rdchk("unmapped", 16'h0040, 32'h0);
      wr(ffs_pkg::IDX_GRP5_LIVE, 32'hFF);
      rdchk("ro_write_ignored", ffs_pkg::IDX_GRP5_LIVE, 32'h0);
   endtask : irq_test

   // ==========================================================
   // main sequence and watchdog
   initial begin
      rst    = 1'b1;
      hsel   = 1'b0;
      haddr  = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize  = 3'h2;
      hwdata = 32'h0;
      st     = '0;
      pon    = 1'b0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      reset_test();
      chan_c_test();
      flags_test();
      id_test();
      irq_test();
      complete_run();
   end

   // the whole run needs well under two thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      complete_run();
   end

endmodule : ffs_status_bench
